// ===== hdl/asyu_pkg.sv
// Constants, register map and shared decoders for the asynchronous serial port block
// What this block does
// - Two select bits choose 8/7/9 or 8+parity.
// - Transmit and receive share length and rate.
// - Transmit pin driven only when drive enabled.
// - Stopped transmitter idles high NRZ, low Manchester.
// - Push-pull or open-drain transmit pin selectable.
// - Nine-bit mode sends tx_ninth_bit as bit eight.
// - Buffer-moved flag sets after holding copied; software clears.
// - Flag cleared mid-frame restarts transmit at frame end.
// - Buffer-moved flag with enable raises transmit interrupt.
// - Bit period (divisor+1) times 8/3 or 32/3.
// - Baud counters reset while their direction is stopped.
// - Fixed-rate mode ignores divisor, prescale, length; eight bits.
// - Holding register copied into shifter at transmit start.
// - Receive end moves shifter; ninth bit; 7-bit MSB zero.
// - Rate mode: programmable, or three fixed rates.
// - Manchester coding selectable for transmit stream.
// - Frame end with flag set: end flag, stop.
// - End flag with enable raises transmit interrupt.
// - Run bit starts; cleared at end if flag set; clear aborts.
// - Parity mode: even/odd generate, receive error reported.
// - Start detect sets receive active; stop clears it.
`default_nettype none
package asyu_pkg;
  // Printed register indices; byte address is four times the index
  localparam logic [15:0] IDX_RX_CTRL  = 16'hFED0;
  localparam logic [15:0] IDX_TX_CTRL  = 16'hFED1;
  localparam logic [15:0] IDX_BAUD     = 16'hFED2;
  localparam logic [15:0] IDX_TX_HOLD  = 16'hFED3;
  localparam logic [15:0] IDX_RX_HOLD  = 16'hFED4;
  localparam logic [15:0] IDX_MODE_SEL = 16'hFED5;
  // Reset values
  localparam logic [7:0]  RST_REG      = 8'h00;
  // Transmit control bit positions
  localparam int TC_RUN   = 7;
  localparam int TC_NINE  = 6;
  localparam int TC_DRIVE = 5;
  localparam int TC_PUSH  = 4;
  localparam int TC_SEVEN = 3;
  localparam int TC_TX_NINTH_BIT = 2;
  localparam int TC_MOVED = 1;
  localparam int TC_MVIE  = 0;
  // Receive control bit positions
  localparam int RC_PRESC = 7;
  localparam int RC_SDET  = 6;
  localparam int RC_ACT   = 5;
  localparam int RC_STPER = 4;
  localparam int RC_ODD   = 3;
  localparam int RC_RX_NINTH_BIT = 2;
  localparam int RC_END   = 1;
  localparam int RC_ENDIE = 0;
  // Mode select bit positions
  localparam int MS_RATE_LO = 3;
  localparam int MS_MANCH   = 2;
  localparam int MS_TX_END_FLAG    = 1;
  localparam int MS_TX_END_IRQ_EN   = 0;
  // Bit period in thirds of a cycle: programmable scale factors
  localparam logic [13:0] SCALE_LO = 14'h0008;
  localparam logic [13:0] SCALE_HI = 14'h0020;
  // Fixed-rate periods in thirds of a subclock cycle (9600/4800/2400 bps)
  localparam logic [13:0] FIX_9600 = 14'h000A;
  localparam logic [13:0] FIX_4800 = 14'h0014;
  localparam logic [13:0] FIX_2400 = 14'h0028;
  // Baud accumulator step, in sixths of a cycle per clock
  localparam logic [14:0] ACC_STEP = 15'h0006;

  // Data bit count from the length selects; fixed mode is always eight
  function automatic logic [3:0] asyu_dlen(input logic nine, input logic seven,
                                           input logic fixed);
    if (fixed) begin
      return 4'h8;
    end else if (nine) begin
      return 4'h9;
    end else if (seven) begin
      return 4'h7;
    end else begin
      return 4'h8;
    end
  endfunction

  // Eight data bits plus parity selected
  function automatic logic asyu_par_mode(input logic nine, input logic seven,
                                         input logic fixed);
    return nine & seven & ~fixed;
  endfunction
endpackage
`default_nettype wire

// ===== hdl/asyu_baud.sv
// Fractional baud tick generator working in sixths of a clock cycle
`default_nettype none
module asyu_baud
  import asyu_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Control
  input  wire logic        clr,
  input  wire logic [13:0] period3,
  // Ticks
  output logic             half_tick,
  output logic             full_tick
);
  logic [14:0] acc_q;   // Phase in sixths of a cycle
  logic [14:0] acc_nxt; // Phase after this clock
  logic [14:0] per6;    // Full period in sixths

  // Sixths let both the half and full points land on the 1/6-cycle grid
  always_comb begin
    per6      = {period3, 1'b0};
    acc_nxt   = acc_q + ACC_STEP;
    full_tick = ~clr & (acc_nxt >= per6);
    half_tick = ~clr & ({1'b0, period3} > acc_q) & (acc_nxt >= {1'b0, period3});
  end

  // Counter held at zero while stopped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_q <= 15'h0000;
    end else if (clr) begin
      acc_q <= 15'h0000;
    end else if (full_tick) begin
      acc_q <= acc_nxt - per6; // Keep the fraction
    end else begin
      acc_q <= acc_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/asyu_top.sv
// Asynchronous serial transmitter/receiver with APB register access
//
// Our own choice: the APB register port.
`default_nettype none
module asyu_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial pins
  input  wire logic        rx_pin,
  output logic             tx_pin_o,
  output logic             tx_pin_oe,
  // Interrupt requests
  output logic             irq_tx,
  output logic             irq_rx
);
  import asyu_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_LOAD, TX_SEND} asyu_tx_st_t;

  // Register storage
  logic [7:0]  baud_divisor_q;     // Divisor n
  logic [7:0]  tx_holding_q;       // Transmit holding
  logic [7:0]  rx_holding_q;       // Receive holding
  logic [2:0]  gp_flags_q;         // General-purpose mode bits
  logic [1:0]  rate_mode_select_q; // Programmable or fixed rate
  logic        manchester_select_q;
  logic        tx_end_flag_q;
  logic        tx_end_irq_en_q;
  logic        tx_run_q;
  logic        nine_bit_select_q;
  logic        tx_port_drive_enable_q;
  logic        tx_push_pull_select_q;
  logic        seven_bit_select_q;
  logic        tx_ninth_bit_q;
  logic        tx_buffer_moved_flag_q;
  logic        tx_buffer_moved_irq_en_q;
  logic        baud_prescale_select_q;
  logic        start_detect_enable_q;
  logic        rx_active_q;
  logic        stop_error_q;
  logic        parity_odd_select_q;
  logic        rx_ninth_bit_q;
  logic        rx_end_flag_q;
  logic        rx_end_irq_en_q;

  // APB helpers
  logic        apb_wr;        // Write takes effect this edge
  logic        setup;         // Setup cycle
  logic [31:0] rd_word;       // Read mux
  logic        hit_any;       // Address maps to a register
  logic [7:0]  wd;            // Write byte

  // Shared configuration
  logic        fixed_mode;
  logic [3:0]  dlen;          // Data bits per frame
  logic        par_mode;
  logic [3:0]  stop_idx;      // Bit index of stop bit
  logic [13:0] period3;       // Bit period in thirds of a cycle

  // Transmit datapath
  asyu_tx_st_t tx_st_q;
  logic [8:0]  tx_shifter_q;
  logic [3:0]  tx_bit_q;
  logic        tx_half_q;     // Second half of a Manchester cell
  logic        tx_half_tick;
  logic        tx_full_tick;
  logic        tx_done;       // Stop bit finished
  logic        tx_line;       // Coded line level
  logic        tx_nrz;

  // Receive datapath
  logic        rx_sync1_q;    // First synchroniser stage
  logic        rx_sync2_q;
  logic        rx_prev_q;     // For edge detection
  logic [8:0]  rx_shifter_q;
  logic [3:0]  rx_bit_q;
  logic        rx_half_tick;
  logic        rx_full_tick;
  logic        rx_start;
  logic        rx_done;
  logic [8:0]  rx_word;       // Received bits aligned to bit 0
  logic        rx_par_err;

  // Address compare against a printed index
  function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
    return a == {14'h0000, idx, 2'b00};
  endfunction

  // Bus decode and strobes
  always_comb begin
    setup   = psel & ~penable;
    apb_wr  = psel & penable & pready & pwrite & ~pslverr;
    wd      = pwdata[7:0];
    hit_any = hit(paddr, IDX_RX_CTRL) | hit(paddr, IDX_TX_CTRL) | hit(paddr, IDX_BAUD)
            | hit(paddr, IDX_TX_HOLD) | hit(paddr, IDX_RX_HOLD) | hit(paddr, IDX_MODE_SEL);
  end

  // Read mux; unmapped reads return zero
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit(paddr, IDX_RX_CTRL)) begin
      rd_word[7:0] = {baud_prescale_select_q, start_detect_enable_q, rx_active_q,
                      stop_error_q, parity_odd_select_q, rx_ninth_bit_q,
                      rx_end_flag_q, rx_end_irq_en_q};
    end else if (hit(paddr, IDX_TX_CTRL)) begin
      rd_word[7:0] = {tx_run_q, nine_bit_select_q, tx_port_drive_enable_q,
                      tx_push_pull_select_q, seven_bit_select_q, tx_ninth_bit_q,
                      tx_buffer_moved_flag_q, tx_buffer_moved_irq_en_q};
    end else if (hit(paddr, IDX_BAUD)) begin
      rd_word[7:0] = baud_divisor_q;
    end else if (hit(paddr, IDX_TX_HOLD)) begin
      rd_word[7:0] = tx_holding_q;
    end else if (hit(paddr, IDX_RX_HOLD)) begin
      rd_word[7:0] = rx_holding_q;
    end else if (hit(paddr, IDX_MODE_SEL)) begin
      rd_word[7:0] = {gp_flags_q, rate_mode_select_q, manchester_select_q,
                      tx_end_flag_q, tx_end_irq_en_q};
    end
  end

  // APB answer: one-cycle access phase, data captured in setup
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_any;
      if (setup) begin
        prdata <= rd_word;
      end
    end
  end

  // Plain software-owned configuration
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      baud_divisor_q           <= RST_REG;
      tx_holding_q             <= RST_REG;
      gp_flags_q               <= RST_REG[7:5];
      rate_mode_select_q       <= RST_REG[4:3];
      manchester_select_q      <= 1'b0;
      tx_end_irq_en_q          <= 1'b0;
      nine_bit_select_q        <= 1'b0;
      tx_port_drive_enable_q   <= 1'b0;
      tx_push_pull_select_q    <= 1'b0;
      seven_bit_select_q       <= 1'b0;
      tx_ninth_bit_q           <= 1'b0;
      tx_buffer_moved_irq_en_q <= 1'b0;
      baud_prescale_select_q   <= 1'b0;
      start_detect_enable_q    <= 1'b0;
      parity_odd_select_q      <= 1'b0;
      rx_end_irq_en_q          <= 1'b0;
    end else if (apb_wr) begin
      if (hit(paddr, IDX_BAUD)) begin
        baud_divisor_q <= wd; // Zero is left to software to avoid
      end
      if (hit(paddr, IDX_TX_HOLD)) begin
        tx_holding_q <= wd;
      end
      if (hit(paddr, IDX_MODE_SEL)) begin
        gp_flags_q          <= wd[7:5];
        rate_mode_select_q  <= wd[MS_RATE_LO+1:MS_RATE_LO];
        manchester_select_q <= wd[MS_MANCH];
        tx_end_irq_en_q     <= wd[MS_TX_END_IRQ_EN];
      end
      if (hit(paddr, IDX_TX_CTRL)) begin
        nine_bit_select_q        <= wd[TC_NINE];
        tx_port_drive_enable_q   <= wd[TC_DRIVE];
        tx_push_pull_select_q    <= wd[TC_PUSH];
        seven_bit_select_q       <= wd[TC_SEVEN];
        tx_ninth_bit_q           <= wd[TC_TX_NINTH_BIT];
        tx_buffer_moved_irq_en_q <= wd[TC_MVIE];
      end
      if (hit(paddr, IDX_RX_CTRL)) begin
        baud_prescale_select_q <= wd[RC_PRESC];
        start_detect_enable_q  <= wd[RC_SDET];
        parity_odd_select_q    <= wd[RC_ODD];
        rx_end_irq_en_q        <= wd[RC_ENDIE];
      end
    end
  end

  // One length and one rate serve both directions
  always_comb begin
    fixed_mode = rate_mode_select_q != 2'b00;
    dlen       = asyu_dlen(nine_bit_select_q, seven_bit_select_q, fixed_mode);
    par_mode   = asyu_par_mode(nine_bit_select_q, seven_bit_select_q, fixed_mode);
    stop_idx   = dlen + 4'h1;
    unique case (rate_mode_select_q)
      2'b00:   period3 = ({6'h00, baud_divisor_q} + 14'h0001)
                         * (baud_prescale_select_q ? SCALE_HI : SCALE_LO);
      2'b01:   period3 = FIX_9600;
      2'b10:   period3 = FIX_4800;
      2'b11:   period3 = FIX_2400;
    endcase
  end

  // Transmit bit timing, cleared unless a frame is being shifted
  asyu_baud u_tx_baud (
    .clk       (clk),
    .rst       (rst),
    .clr       (~tx_run_q | (tx_st_q != TX_SEND)),
    .period3   (period3),
    .half_tick (tx_half_tick),
    .full_tick (tx_full_tick)
  );

  // Receive bit timing, cleared while no frame is in progress
  asyu_baud u_rx_baud (
    .clk       (clk),
    .rst       (rst),
    .clr       (~rx_active_q),
    .period3   (period3),
    .half_tick (rx_half_tick),
    .full_tick (rx_full_tick)
  );

  assign tx_done = (tx_st_q == TX_SEND) & tx_run_q & tx_full_tick & (tx_bit_q == stop_idx);

  // Transmit run bit: software starts or aborts, hardware ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_run_q <= 1'b0;
    end else if (tx_done) begin
      tx_run_q <= ~tx_buffer_moved_flag_q; // Continuous mode stays on
    end else if (apb_wr && hit(paddr, IDX_TX_CTRL)) begin
      tx_run_q <= wd[TC_RUN];
    end
  end

  // Transmit sequencer and shifter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_q      <= TX_IDLE;
      tx_shifter_q <= 9'h000;
      tx_bit_q     <= 4'h0;
      tx_half_q    <= 1'b0;
    end else if (!tx_run_q) begin
      tx_st_q   <= TX_IDLE; // Clearing run aborts at once
      tx_half_q <= 1'b0;
    end else begin
      unique case (tx_st_q)
        TX_IDLE: begin
          tx_st_q <= TX_LOAD;
        end
        TX_LOAD: begin
          // Holding copied with the ninth or parity bit above it
          tx_shifter_q <= {par_mode ? (^tx_holding_q) ^ parity_odd_select_q
                                    : tx_ninth_bit_q, tx_holding_q};
          tx_bit_q     <= 4'h0;
          tx_half_q    <= 1'b0;
          tx_st_q      <= TX_SEND;
        end
        TX_SEND: begin
          if (tx_half_tick) begin
            tx_half_q <= 1'b1;
          end
          if (tx_full_tick) begin
            tx_half_q <= 1'b0;
            if (tx_bit_q == stop_idx) begin
              // Reload next frame, one cycle gap
              tx_st_q <= tx_buffer_moved_flag_q ? TX_IDLE : TX_LOAD;
            end else begin
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_bit_q != 4'h0) begin
                tx_shifter_q <= {1'b0, tx_shifter_q[8:1]}; // LSB first
              end
            end
          end
        end
      endcase
    end
  end

  // Buffer-moved flag: set on load, software write clears; set wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_buffer_moved_flag_q <= 1'b0;
    end else if (tx_st_q == TX_LOAD && tx_run_q) begin
      tx_buffer_moved_flag_q <= 1'b1;
    end else if (apb_wr && hit(paddr, IDX_TX_CTRL)) begin
      tx_buffer_moved_flag_q <= wd[TC_MOVED];
    end
  end

  // Transmit end flag: set when a frame ends with nothing new loaded
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_end_flag_q <= 1'b0;
    end else if (tx_done && tx_buffer_moved_flag_q) begin
      tx_end_flag_q <= 1'b1;
    end else if (apb_wr && hit(paddr, IDX_MODE_SEL)) begin
      tx_end_flag_q <= wd[MS_TX_END_FLAG];
    end
  end

  // Line level: start low, data, stop high; Manchester inverts second half
  always_comb begin
    if (tx_bit_q == 4'h0) begin
      tx_nrz = 1'b0;
    end else if (tx_bit_q == stop_idx) begin
      tx_nrz = 1'b1;
    end else begin
      tx_nrz = tx_shifter_q[0];
    end
    if (!tx_run_q || tx_st_q != TX_SEND) begin
      tx_line = ~manchester_select_q; // Idle level
    end else if (manchester_select_q) begin
      tx_line = tx_nrz ^ tx_half_q;
    end else begin
      tx_line = tx_nrz;
    end
  end

  // Pin driver: open drain only ever pulls low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_pin_o  <= 1'b0;
      tx_pin_oe <= 1'b0;
    end else if (!tx_port_drive_enable_q) begin
      tx_pin_o  <= 1'b0;
      tx_pin_oe <= 1'b0;
    end else if (tx_push_pull_select_q) begin
      tx_pin_o  <= tx_line;
      tx_pin_oe <= 1'b1;
    end else begin
      tx_pin_o  <= 1'b0;
      tx_pin_oe <= ~tx_line;
    end
  end

  // Receive pin synchroniser and edge history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_sync1_q <= 1'b1;
      rx_sync2_q <= 1'b1;
      rx_prev_q  <= 1'b1;
    end else begin
      rx_sync1_q <= rx_pin;
      rx_sync2_q <= rx_sync1_q;
      rx_prev_q  <= rx_sync2_q;
    end
  end

  // Start on a falling edge; finish at the middle of the stop bit
  always_comb begin
    rx_start = start_detect_enable_q & ~rx_active_q & rx_prev_q & ~rx_sync2_q;
    rx_done  = rx_active_q & rx_half_tick & (rx_bit_q == stop_idx);
    unique case (dlen)
      4'h9:    rx_word = rx_shifter_q;
      4'h7:    rx_word = {2'b00, rx_shifter_q[8:2]};
      default: rx_word = {1'b0, rx_shifter_q[8:1]};
    endcase
    // Error when the received parity does not match the chosen sense
    rx_par_err = (^rx_word) ^ parity_odd_select_q;
  end

  // Receive active: hardware sets and ends, software may abort
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_active_q <= 1'b0;
    end else if (rx_start) begin
      rx_active_q <= 1'b1;
    end else if (rx_done) begin
      rx_active_q <= 1'b0;
    end else if (apb_wr && hit(paddr, IDX_RX_CTRL) && !wd[RC_ACT]) begin
      rx_active_q <= 1'b0;
    end
  end

  // Receive sampler: mid-bit samples shift in from the top
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_shifter_q <= 9'h000;
      rx_bit_q     <= 4'h0;
    end else if (rx_start) begin
      rx_bit_q <= 4'h0;
    end else if (rx_active_q) begin
      if (rx_half_tick && rx_bit_q != 4'h0 && rx_bit_q != stop_idx) begin
        rx_shifter_q <= {rx_sync2_q, rx_shifter_q[8:1]}; // LSB first
      end
      if (rx_full_tick) begin
        rx_bit_q <= rx_bit_q + 4'h1;
      end
    end
  end

  // Receive completion: holding, ninth bit, flags; set wins over clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_holding_q   <= RST_REG;
      rx_ninth_bit_q <= 1'b0;
      rx_end_flag_q  <= 1'b0;
      stop_error_q   <= 1'b0;
    end else if (rx_done) begin
      rx_holding_q   <= (dlen == 4'h7) ? {1'b0, rx_word[6:0]} : rx_word[7:0];
      rx_ninth_bit_q <= par_mode ? rx_par_err : (dlen == 4'h9) ? rx_word[8]
                                                               : rx_ninth_bit_q;
      rx_end_flag_q  <= 1'b1;
      stop_error_q   <= ~rx_sync2_q;
    end else if (apb_wr) begin
      if (hit(paddr, IDX_RX_HOLD)) begin
        rx_holding_q <= wd;
      end
      if (hit(paddr, IDX_RX_CTRL)) begin
        rx_ninth_bit_q <= wd[RC_RX_NINTH_BIT];
        rx_end_flag_q  <= wd[RC_END];
        stop_error_q   <= wd[RC_STPER];
      end
    end
  end

  // Interrupt requests, registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_tx <= 1'b0;
      irq_rx <= 1'b0;
    end else begin
      irq_tx <= (tx_buffer_moved_flag_q & tx_buffer_moved_irq_en_q)
              | (tx_end_flag_q & tx_end_irq_en_q);
      irq_rx <= rx_end_flag_q & rx_end_irq_en_q;
    end
  end
endmodule
`default_nettype wire

// ===== dv/asyu_monitor.sv
// Port checker for the serial port block
`default_nettype none
module asyu_monitor
  import asyu_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pin
  input wire logic        tx_pin_o,
  input wire logic        tx_pin_oe
);
  logic [7:0]  tc_q; // Control byte as written
  logic [29:0] ix;   // Word index
  logic        hit;  // Mapped register
  logic        wtc;  // Control write done
  assign ix = paddr[31:2];
  assign hit = paddr[1:0] == 2'h0 && ix >= 30'(IDX_RX_CTRL) && ix <= 30'(IDX_MODE_SEL);
  assign wtc = psel && penable && pready && pwrite && ix == 30'(IDX_TX_CTRL);
  // Only software-owned bits are used, hardware ones drift
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tc_q <= 8'h00;
    end else if (wtc) begin
      tc_q <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("long pready");
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no pready");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("stray pready");
  property p_err; psel && !penable |=> pslverr == !$past(hit); endproperty
  a_err: assert property (p_err) else $error("bad pslverr");
  property p_hi; pready |-> prdata[31:8] == 24'h000000; endproperty
  a_hi: assert property (p_hi) else $error("upper bits set");
  property p_drv; (!tc_q[TC_DRIVE]) [*2] |-> !tx_pin_oe; endproperty
  a_drv: assert property (p_drv) else $error("pin driven");
  property p_odr; (!tc_q[TC_PUSH]) [*2] |-> !(tx_pin_oe && tx_pin_o); endproperty
  a_odr: assert property (p_odr) else $error("high drive");
  property p_go;
    wtc && pwdata[7] && pwdata[5] && pwdata[4] && !tx_pin_oe |-> ##[2:6] !tx_pin_o;
  endproperty
  a_go: assert property (p_go) else $error("no start bit");
endmodule
bind asyu_top asyu_monitor asyu_monitor_inst (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe)
);
`default_nettype wire

// ===== dv/asyu_remote.sv
// Remote serial node model
`default_nettype none
module asyu_remote (
  // Clock
  input  wire logic clk,
  // Lines
  input  wire logic tx_line,
  output var logic  rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rx_pin = 1'b1; // Idle high
  // Start, n bits LSB first, stop
  task automatic send(input logic [8:0] d, input int n);
    for (int i = -1; i <= n; i++) begin
      rx_pin <= i < 0 ? 1'b0 : i == n ? 1'b1 : d[i];
      repeat (16) @(posedge clk);
    end
  endtask
  // Sample mid-bit, p cycles a bit
  task automatic recv(output logic [8:0] d, output logic s, input int n, input int p);
    d = 9'h000;
    @(negedge tx_line);
    repeat (p / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      repeat (p) @(posedge clk);
      d[i] = tx_line;
    end
    repeat (p) @(posedge clk);
    s = tx_line;
  endtask
endmodule
`default_nettype wire

// ===== dv/async_serial_tx_rx_control_tb_top.sv
// Self-checking bench for the serial port block
`default_nettype none
module async_serial_tx_rx_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import asyu_pkg::*;
  logic        clk, rst, psel, penable, pwrite, rx_pin, err, stp;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic        pready, pslverr, tx_pin_o, tx_pin_oe, irq_tx, irq_rx;
  logic [8:0]  d;
  int          failures, checked, cyc;
  wire logic   tx_line = tx_pin_oe ? tx_pin_o : 1'b1; // Pull-up
  // Cases: control, frame, divisor, bits, mode, cycles a bit
  logic [7:0]  tcv [5] = '{8'hB0, 8'hB8, 8'hF0, 8'hF8, 8'hF0};
  logic [8:0]  exv [5] = '{9'h0A7, 9'h027, 9'h0A7, 9'h1A7, 9'h0A7};
  logic [7:0]  bdv [5] = '{8'h05, 8'h05, 8'h02, 8'h02, 8'h05};
  int          nbv [5] = '{8, 7, 9, 9, 8};
  // Last case: slowest fixed rate, 40 thirds, bench clock stands in for the subclock
  logic [7:0]  msv [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h18};
  int          pv  [5] = '{16, 16, 32, 32, 13};
  asyu_top asyu_top_inst (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin_o(tx_pin_o),
    .tx_pin_oe(tx_pin_oe), .irq_tx(irq_tx), .irq_rx(irq_rx));
  asyu_remote asyu_remote_inst (.clk(clk), .tx_line(tx_line), .rx_pin(rx_pin));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %0h want %0h", $time, got, exp);
    end
  endtask
  // One transfer, then an idle cycle
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {14'h0000, idx, 2'h0};
    pwdata <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd);
  endtask
  task automatic rc(input logic [15:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, exp});
  endtask
  // Poll until the transmitter stops
  task automatic txw();
    do apb(1'b0, IDX_TX_CTRL, 8'h00); while (rd[TC_RUN] !== 1'b0);
  endtask
  task automatic end_of_test();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      rc(IDX_RX_CTRL + 16'(i), 8'h00);
    end
    apb(1'b0, 16'hFED6, 8'h00);
    chk(32'(err), 32'h1);
    wr(IDX_MODE_SEL, 8'hE4);
    rc(IDX_MODE_SEL, 8'hE4);
    wr(IDX_TX_CTRL, 8'h30);
    @(posedge clk);
    chk(32'(tx_line), 32'h0);
    wr(IDX_MODE_SEL, 8'h00);
    @(posedge clk);
    chk(32'(tx_line), 32'h1);
    $display("test registers done");
    // Each length mode; divisor 2 pairs with the coarse prescale
    for (int i = 0; i < 5; i++) begin
      wr(IDX_BAUD, bdv[i]);
      wr(IDX_RX_CTRL, {bdv[i][1], 7'h00});
      wr(IDX_TX_CTRL, 8'h00);
      wr(IDX_MODE_SEL, msv[i]);
      wr(IDX_TX_HOLD, 8'hA7);
      fork
        asyu_remote_inst.recv(d, stp, nbv[i], pv[i]);
        wr(IDX_TX_CTRL, tcv[i]);
      join
      chk(32'(d), 32'(exv[i]));
      chk(32'(stp), 32'h1);
      txw();
      rc(IDX_TX_CTRL, tcv[i] & 8'h7F | 8'h02);
      rc(IDX_MODE_SEL, msv[i] | 8'h02);
      wr(IDX_MODE_SEL, 8'h00);
    end
    wr(IDX_BAUD, 8'h05);
    wr(IDX_RX_CTRL, 8'h00);
    wr(IDX_TX_CTRL, 8'h00);
    wr(IDX_TX_HOLD, 8'h11);
    fork
      begin
        asyu_remote_inst.recv(d, stp, 8, 16);
        chk(32'(d), 32'h11);
        asyu_remote_inst.recv(d, stp, 8, 16);
        chk(32'(d), 32'h22);
      end
      begin
        wr(IDX_TX_CTRL, 8'hB0);
        do apb(1'b0, IDX_TX_CTRL, 8'h00); while (rd[TC_MOVED] !== 1'b1);
        rc(IDX_TX_CTRL, 8'hB2);
        wr(IDX_TX_HOLD, 8'h22);
        wr(IDX_TX_CTRL, 8'hB0);
      end
    join
    txw();
    chk(rd, 32'h00000032);
    rc(IDX_MODE_SEL, 8'h02);
    wr(IDX_MODE_SEL, 8'h03);
    @(posedge clk);
    chk(32'(irq_tx), 32'h1);
    wr(IDX_MODE_SEL, 8'h00);
    wr(IDX_TX_CTRL, 8'h03);
    @(posedge clk);
    chk(32'(irq_tx), 32'h1);
    $display("test transmit done");
    wr(IDX_TX_CTRL, 8'h40);
    wr(IDX_RX_CTRL, 8'h41);
    asyu_remote_inst.send(9'h1A5, 9);
    rc(IDX_RX_HOLD, 8'hA5);
    rc(IDX_RX_CTRL, 8'h47);
    chk(32'(irq_rx), 32'h1);
    wr(IDX_TX_CTRL, 8'h08);
    wr(IDX_RX_CTRL, 8'h40);
    asyu_remote_inst.send(9'h1FF, 7);
    rc(IDX_RX_HOLD, 8'h7F);
    $display("test receive done");
    end_of_test();
  end
endmodule
`default_nettype wire
